// File: shared/sspt_consts.vh
// Constants for the synchronous serial position transmitter.
// Assumes a 250 MHz system clock; included by its bare name.
`ifndef SSPT_CONSTS_VH
`define SSPT_CONSTS_VH
`define SSPT_POS_W 24
`define SSPT_WORD_BITS 25
`define SSPT_CNT_W 5
`define SSPT_CLK_MHZ 250
`define SSPT_MONO_US 20
`define SSPT_MONO_CYC (`SSPT_MONO_US * `SSPT_CLK_MHZ)
`define SSPT_FIFO_W 24
`define SSPT_FIFO_D 16
`define SSPT_FIFO_AW 4
`endif

// File: hdl/sspt_top.v
// Synchronous serial position transmitter and its position FIFO.
// Assumes the link clock arrives asynchronously and idles high, and that
// the drive pushes position samples on the system clock.
`timescale 1ns/1ns
`default_nettype none
`include "sspt_consts.vh"

// Behaviour
// - One 25-bit word goes out on the data line, one bit per shift clock.
// - Each word is one filler bit followed by 24 position bits.
// - Position is captured on the first falling edge and held for the word.
// - New capture only after a monoflop-long clock pause, with or without a full word.
// - Clocking on without a pause repeats the previously captured position.
// - At power-up the position starts from the encoder's absolute position.

// Parameterised FIFO holding position samples between drive and shifter.
module sspt_fifo #(
  parameter W = 24,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire srst,
  input wire [W-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [W-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != D);
  assign out_valid = (cnt_q != 0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Pointers and fill count; full and empty come from the count.
  always @(posedge clk) begin
    if (srst) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  // Storage is written without reset since empty words are never read.
  always @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule

module sspt_top #(
  parameter MONO_CYC = `SSPT_MONO_CYC
) (
  input wire clk,
  input wire srst,
  input wire [`SSPT_POS_W-1:0] pos_data,
  input wire pos_valid,
  output reg pos_ready,
  input wire [`SSPT_POS_W-1:0] enc_pos,
  input wire enc_valid,
  input wire link_clk,
  output reg link_data,
  output reg busy,
  output reg init_done
);
  reg [2:0] lclk_sync_q;
  reg [`SSPT_POS_W-1:0] cur_pos_q;
  reg [`SSPT_WORD_BITS-1:0] shift_q;
  reg [`SSPT_CNT_W-1:0] bit_cnt_q;
  reg [31:0] idle_cnt_q;
  reg fresh_q;
  reg lclk_q;
  wire lclk_stable;
  wire fall;
  wire rise;
  wire [`SSPT_POS_W-1:0] f_data;
  wire f_valid;
  wire f_in_ready;

  // Last bit of a word; the counter wraps here, so continued clocking repeats.
  function last_bit;
    input [`SSPT_CNT_W-1:0] cnt;
    begin
      last_bit = (cnt == `SSPT_WORD_BITS - 1);
    end
  endfunction

  // Word boundary: no bit of the current word has gone out yet.
  function at_boundary;
    input [`SSPT_CNT_W-1:0] cnt;
    begin
      at_boundary = (cnt == {`SSPT_CNT_W{1'b0}});
    end
  endfunction

  // Frame layout: the filler bit leads and the position follows MSB first.
  // Keeping the layout in one place lets the filler level change without
  // touching the shifter itself.
  function [`SSPT_WORD_BITS-1:0] frame_word;
    input [`SSPT_POS_W-1:0] pos;
    begin
      frame_word = {1'b0, pos};
    end
  endfunction

  // Samples wait in the FIFO; the newest one drained becomes current.
  sspt_fifo #(
    .W(`SSPT_FIFO_W),
    .D(`SSPT_FIFO_D),
    .AW(`SSPT_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .srst(srst),
    .in_data(pos_data),
    .in_valid(pos_valid),
    .in_ready(f_in_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(init_done)
  );

  // A clock change counts once stages two and three agree.
  assign lclk_stable = (lclk_sync_q[1] == lclk_sync_q[2]);
  assign fall = lclk_stable && lclk_q && !lclk_sync_q[2];
  assign rise = lclk_stable && !lclk_q && lclk_sync_q[2];

  // Three-stage synchroniser on the shift clock pin.
  // Edges are seen three to four cycles late, so each clock phase must last
  // several system clocks; the slowest legal link clock is far above that.
  always @(posedge clk) begin
    lclk_sync_q <= {lclk_sync_q[1:0], link_clk};
  end

  // Current position: encoder value first, then drained FIFO samples.
  // The FIFO is not drained until init, so early samples back-pressure.
  always @(posedge clk) begin
    if (srst) begin
      cur_pos_q <= {`SSPT_POS_W{1'b0}};
      init_done <= 1'b0;
      pos_ready <= 1'b0;
    end else begin
      pos_ready <= f_in_ready;
      if (!init_done) begin
        if (enc_valid) begin
          cur_pos_q <= enc_pos;
          init_done <= 1'b1;
        end
      end else if (f_valid) begin
        cur_pos_q <= f_data;
      end
    end
  end

  // Shifter: capture on first falling edge, update data on rising edges.
  // A long pause rearms capture; without it the old word repeats.
  always @(posedge clk) begin
    if (srst) begin
      lclk_q <= 1'b1;
      shift_q <= {`SSPT_WORD_BITS{1'b1}};
      bit_cnt_q <= 5'h00;
      idle_cnt_q <= 32'h00000000;
      fresh_q <= 1'b1;
      link_data <= 1'b1;
      busy <= 1'b0;
    end else begin
      if (lclk_stable) begin
        lclk_q <= lclk_sync_q[2];
      end
      if (fall || rise) begin
        idle_cnt_q <= 32'h00000000;
      end else if (idle_cnt_q < MONO_CYC) begin
        idle_cnt_q <= idle_cnt_q + 32'h00000001;
      end else begin
        // Monoflop expired: the counter clears and a fresh capture re-arms, after a partial word too.
        if (at_boundary(bit_cnt_q)) begin
          fresh_q <= 1'b1;
        end
        bit_cnt_q <= 5'h00;
        busy <= 1'b0;
        link_data <= 1'b1;
      end
      // The first falling edge of a word either captures or replays.
      if (fall && at_boundary(bit_cnt_q)) begin
        busy <= 1'b1;
        if (fresh_q) begin
          shift_q <= frame_word(cur_pos_q);
          fresh_q <= 1'b0;
        end else begin
          shift_q <= shift_q;
        end
      end
      if (rise && busy) begin
        link_data <= shift_q[`SSPT_WORD_BITS-1-bit_cnt_q];
        // A whole word leaves the counter at the boundary; the monoflop also clears it,
        // so a fresh capture re-arms after a pause either way.
        if (last_bit(bit_cnt_q)) begin
          bit_cnt_q <= 5'h00; // Continued clocking restarts the old word.
          fresh_q <= 1'b0;
        end else begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: test/sspt_monitor.sv
// Checker on the transmitter's ports.
// Bound into sspt_top; MONO_CYC follows the design's value.
`timescale 1ns/1ns
`default_nettype none
module sspt_monitor #(parameter MONO_CYC = 200) (
  input wire clk,
  input wire srst,
  input wire enc_valid,
  input wire link_clk,
  input wire link_data,
  input wire busy,
  input wire init_done
);
  reg [15:0] idle_q;
  // Cycles since the shift clock pin last moved; wraps only on very long idles.
  always @(posedge clk) idle_q <= (srst || link_clk != $past(link_clk)) ? 16'h0 : idle_q + 16'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  reset_idle_a: assert property (disable iff (1'h0) srst |=> link_data && !busy && !init_done)
    else $error("reset state wrong");
  init_take_a: assert property (enc_valid && !init_done |=> init_done)
    else $error("encoder start not taken");
  fall_busy_a: assert property ($fell(link_clk) |-> ##[1:8] busy)
    else $error("no capture on falling edge");
  idle_high_a: assert property (!busy |-> link_data)
    else $error("data not idle high");
  shift_edge_a: assert property ($changed(link_data) && $past(busy) |-> $past(link_clk, 3) || $past(link_clk, 5))
    else $error("data moved off a rising edge");
  mono_end_a: assert property ($fell(busy) |-> idle_q >= MONO_CYC && idle_q <= MONO_CYC + 8)
    else $error("monoflop length wrong");
  no_drop_a: assert property (busy && $changed(link_clk) |=> busy[*8])
    else $error("busy dropped while clocking");
endmodule
`default_nettype wire

// File: test/sspt_ctrl_model.sv
// Controller model clocking whole words out of the transmitter.
// Assumes answers on rising edges; the clock stands high between words.
`timescale 1ns/1ns
`default_nettype none
module sspt_ctrl_model (
  output var logic link_clk,
  input wire link_data
);
  initial link_clk = 1'h1;
  // Exactly 25 clock periods per word; the clock then stands high.
  // Each bit is taken late in the high phase, long after the rising edge moved it.
  // The bench link runs at 125 ns to keep runs short; the shifter only needs
  // each phase to span a few system clocks.
  task read_word(output logic [24:0] w);
    integer i;
    #1;
    for (i = 0; i < 25; i = i + 1) begin
      link_clk = 1'h0;
      #62 link_clk = 1'h1;
      #63 w = {w[23:0], link_data};
    end
  endtask
endmodule
`default_nettype wire

// File: test/sspt_top_bench.sv
// Bench for the transmitter with its controller model.
// Assumes MONO_CYC shortens the monoflop to 200 cycles.
`timescale 1ns/1ns
`default_nettype none
module sspt_top_bench;
  localparam int MONO = 200;
  logic clk = 1'h0, srst = 1'h1, pos_valid = 1'h0, enc_valid = 1'h0;
  logic [23:0] pos_data = 24'h0, enc_pos = 24'h0, v, u;
  logic [24:0] w;
  wire link_clk, link_data, busy, init_done, pos_ready;
  integer seed = 32'h240c, fail_count = 0, compares = 0, i, n;
  always #2 clk = ~clk;
  sspt_top #(.MONO_CYC(MONO)) DUT (.clk(clk), .srst(srst), .pos_data(pos_data), .pos_valid(pos_valid),
    .pos_ready(pos_ready), .enc_pos(enc_pos), .enc_valid(enc_valid), .link_clk(link_clk),
    .link_data(link_data), .busy(busy), .init_done(init_done));
  sspt_ctrl_model ctrl (.link_clk(link_clk), .link_data(link_data));
  task check(input logic [24:0] got, input logic [24:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("ERROR %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task check_flag(input logic got, input logic exp);
    compares = compares + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("ERROR %0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Expected word: filler bit first, then the position MSB first.
  function logic [24:0] word_of(input logic [23:0] p);
    word_of = {1'h0, p};
  endfunction
  // Holds reset for three edges, then looks at the idle state once settled.
  task do_reset;
    @(posedge clk);
    srst <= 1'h1;
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    @(negedge clk);
    check_flag(link_data, 1'h1);
    check_flag(busy, 1'h0);
    check_flag(init_done, 1'h0);
  endtask
  // Offers the encoder start value; it is taken on the first edge it is seen.
  task start(input logic [23:0] e);
    @(posedge clk);
    enc_pos <= e;
    enc_valid <= 1'h1;
    repeat (2) @(posedge clk);
    enc_valid <= 1'h0;
    @(negedge clk);
    check_flag(init_done, 1'h1);
  endtask
  // Pushes one sample, then lets the link idle for cnt cycles.
  task pause_push(input logic [23:0] d, input integer cnt);
    @(posedge clk);
    pos_data <= d;
    pos_valid <= 1'h1;
    @(posedge clk);
    pos_valid <= 1'h0;
    repeat (cnt) @(posedge clk);
  endtask
  initial begin
    v = $random(seed);
    do_reset;
    start(v);
    ctrl.read_word(w);
    check(w, word_of(v));
    @(negedge clk);
    check_flag(busy, 1'h1);
    for (n = 0; n < 4; n = n + 1) begin
      u = (n == 0) ? 24'hFFFFFF : (n == 1) ? 24'h000000 : $random(seed);
      pause_push(u, MONO + 20);
      @(negedge clk);
      check_flag(busy, 1'h0);
      check_flag(link_data, 1'h1);
      ctrl.read_word(w);
      check(w, word_of(u));
      v = $random(seed);
      pause_push(v, 2);
      ctrl.read_word(w);
      check(w, word_of(u));
      ctrl.read_word(w);
      check(w, word_of(u));
    end
    // Second reset; the FIFO fills before init because nothing drains it.
    repeat (MONO + 20) @(posedge clk);
    do_reset;
    for (i = 0; i < 20; i = i + 1) begin
      @(posedge clk);
      pos_data <= (i < 10) ? $random(seed) : v;
      pos_valid <= 1'h1;
    end
    @(posedge clk);
    pos_valid <= 1'h0;
    @(negedge clk);
    check_flag(pos_ready, 1'h0);
    start(24'hA5A5A5);
    repeat (60) @(posedge clk);
    @(negedge clk);
    check_flag(pos_ready, 1'h1);
    ctrl.read_word(w);
    check(w, word_of(v));
    print_verdict;
  end
endmodule
bind sspt_top sspt_monitor #(.MONO_CYC(MONO_CYC)) mon (.clk(clk), .srst(srst), .enc_valid(enc_valid),
  .link_clk(link_clk), .link_data(link_data), .busy(busy), .init_done(init_done));
`default_nettype wire
